/* File: src/lfm_top.sv */
// Operation
// - input low past delay raises load fault
// - config selects off, torque, speed, load
// - failure source selectable, default constant one
// - probe on input three, to 32 kHz
// - invert bit three inverts probe input
// - edge select zero rising, one falling
// - speed from spacing and pulses per rev
// - no pulse in max time, speed zero
// - probe speed times gear factor
// - deviation above permissible value is excessive
// - response off, alarm or fault per condition
// - delay applies before deviation response
// - load speed source selectable, default none
`default_nettype none
module lfm_top
    import lfm_pkg::*;
#(
    parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        motor_on_i,
    input  wire logic [15:0] motor_speed_actual_i,
    input  wire logic [3:0]  din_i,
    input  wire logic [2:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    output logic             load_failure_fault_o,
    output logic             deviation_alarm_o,
    output logic             deviation_fault_o,
    output logic      [15:0] probe_speed_result_o
);
    typedef struct packed {
        logic [1:0]  load_monitor_config;
        logic [2:0]  deviation_response_select;
        logic        probe_edge_select;
        logic [3:0]  probe_invert_mask;
        logic [2:0]  failure_detect_source;
        logic        load_speed_source;
        logic [31:0] load_monitor_delay;
        logic [31:0] probe_max_measure_time;
        logic [7:0]  probe_pulses_per_rev;
        logic [7:0]  probe_gear_factor;
        logic [15:0] permissible_speed_deviation;
        logic [17:0] ms_cnt;
        logic        ms_tick;
        logic        load_flt;
        logic        dev_flt;
        logic        dev_alm;
        logic [31:0] rdata;
    } lfm_top_st_t;

    lfm_top_st_t r;
    lfm_top_st_t next_r;

    lfm_probe_if pif ();

    logic        fail_in;
    logic        fail_cond;
    logic        fail_done;
    logic [15:0] load_speed;
    logic        too_low;
    logic        too_high;
    logic        dev_sel;
    logic        dev_cond;
    logic        dev_done;
    logic        resp_alarm;
    logic        resp_fault;
    logic [31:0] status_word;
    logic [31:0] config_word;

    // selected failure-detect signal: code 0 is a constant one
    function automatic logic fail_select(input logic [2:0] src, input logic [3:0] din);
        logic v;
        v = 1'b1;
        if (src != 3'h0 && src <= 3'h4) begin
            v = din[2'(src - 3'h1)];
        end
        return v;
    endfunction

    // a exceeds b by more than d, widened against overflow
    function automatic logic exceeds(input logic [15:0] a, input logic [15:0] b, input logic [15:0] d);
        return {1'b0, a} > ({1'b0, b} + {1'b0, d});
    endfunction

    assign fail_in   = fail_select(r.failure_detect_source, din_i);
    assign fail_cond = (r.load_monitor_config != MON_OFF) && motor_on_i && !fail_in;

    lfm_timer u_fail_tmr (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .cond_i     (fail_cond),
        .tick_i     (r.ms_tick),
        .limit_i    (r.load_monitor_delay),
        .done_o     (fail_done)
    );

    // load speed source, zero when none
    assign load_speed = r.load_speed_source ? pif.speed : 16'h0;
    assign too_low  = exceeds(motor_speed_actual_i, load_speed, r.permissible_speed_deviation);
    assign too_high = exceeds(load_speed, motor_speed_actual_i, r.permissible_speed_deviation);

    always_comb begin
        dev_sel = 1'b0;
        unique case (r.deviation_response_select)
            3'h1, 3'h4: dev_sel = too_low;
            3'h2, 3'h5: dev_sel = too_high;
            3'h3, 3'h6: dev_sel = too_low | too_high;
            default:    dev_sel = 1'b0;
        endcase
    end

    assign resp_alarm = (r.deviation_response_select >= 3'h1) && (r.deviation_response_select <= 3'h3);
    assign resp_fault = (r.deviation_response_select >= 3'h4) && (r.deviation_response_select <= 3'h6);

    assign dev_cond = (r.load_monitor_config == MON_SPEED) && motor_on_i && dev_sel;

    lfm_timer u_dev_tmr (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .cond_i     (dev_cond),
        .tick_i     (r.ms_tick),
        .limit_i    (r.load_monitor_delay),
        .done_o     (dev_done)
    );

    assign pif.edge_sel = r.probe_edge_select;
    assign pif.invert   = r.probe_invert_mask[INV_PROBE_BIT];
    assign pif.ppr      = r.probe_pulses_per_rev;
    assign pif.gear     = r.probe_gear_factor;
    assign pif.max_ms   = r.probe_max_measure_time;
    assign pif.ms_tick  = r.ms_tick;

    lfm_probe u_probe (
        .core_clk_i          (core_clk_i),
        .rst_i               (rst_i),
        .pulse_input_three_i (din_i[3]),
        .pif                 (pif)
    );

    always_comb begin
        config_word = 32'h0;
        config_word[CFG_MON_LSB +: 2]  = r.load_monitor_config;
        config_word[CFG_RESP_LSB +: 3] = r.deviation_response_select;
        config_word[CFG_EDGE_BIT]      = r.probe_edge_select;
        config_word[CFG_INV_LSB +: 4]  = r.probe_invert_mask;
        config_word[CFG_FSRC_LSB +: 3] = r.failure_detect_source;
        config_word[CFG_LSRC_BIT]      = r.load_speed_source;
        status_word = 32'h0;
        status_word[ST_LOAD_FLT] = r.load_flt;
        status_word[ST_DEV_FLT]  = r.dev_flt;
        status_word[ST_DEV_ALM]  = r.dev_alm;
    end

    always_comb begin
        next_r = r;
        // millisecond enable
        next_r.ms_tick = 1'b0;
        if (r.ms_cnt >= 18'(MS_CYCLES - 1)) begin
            next_r.ms_cnt  = 18'h0;
            next_r.ms_tick = 1'b1;
        end else begin
            next_r.ms_cnt = r.ms_cnt + 18'h1;
        end

        if (reg_wr_i) begin
            unique case (reg_addr_i)
                A_CONFIG: begin
                    next_r.load_monitor_config       = reg_wdata_i[CFG_MON_LSB +: 2];
                    next_r.deviation_response_select = reg_wdata_i[CFG_RESP_LSB +: 3];
                    next_r.probe_edge_select         = reg_wdata_i[CFG_EDGE_BIT];
                    next_r.probe_invert_mask         = reg_wdata_i[CFG_INV_LSB +: 4];
                    next_r.failure_detect_source     = reg_wdata_i[CFG_FSRC_LSB +: 3];
                    next_r.load_speed_source         = reg_wdata_i[CFG_LSRC_BIT];
                end
                A_DELAY:   next_r.load_monitor_delay          = reg_wdata_i;
                A_MAXMEAS: next_r.probe_max_measure_time      = reg_wdata_i;
                A_PPR:     next_r.probe_pulses_per_rev        = reg_wdata_i[7:0];
                A_GEAR:    next_r.probe_gear_factor           = reg_wdata_i[7:0];
                A_DEV:     next_r.permissible_speed_deviation = reg_wdata_i[15:0];
                A_STATUS: begin
                    // write one to clear a sticky fault
                    if (reg_wdata_i[ST_LOAD_FLT]) begin
                        next_r.load_flt = 1'b0;
                    end
                    if (reg_wdata_i[ST_DEV_FLT]) begin
                        next_r.dev_flt = 1'b0;
                    end
                end
                A_SPEED: begin
                end
            endcase
        end

        // sticky load fault, set beats clear
        if (fail_done) begin
            next_r.load_flt = 1'b1;
        end
        if (dev_done && resp_fault) begin
            next_r.dev_flt = 1'b1;
        end
        next_r.dev_alm = dev_done && resp_alarm;

        next_r.rdata = 32'h0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                A_CONFIG:  next_r.rdata = config_word;
                A_DELAY:   next_r.rdata = r.load_monitor_delay;
                A_MAXMEAS: next_r.rdata = r.probe_max_measure_time;
                A_PPR:     next_r.rdata = {24'h0, r.probe_pulses_per_rev};
                A_GEAR:    next_r.rdata = {24'h0, r.probe_gear_factor};
                A_DEV:     next_r.rdata = {16'h0, r.permissible_speed_deviation};
                A_STATUS:  next_r.rdata = status_word;
                A_SPEED:   next_r.rdata = {16'h0, pif.speed};
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            r                             <= '0;
            r.load_monitor_config         <= RST_MON;
            r.deviation_response_select   <= RST_RESP;
            r.probe_edge_select           <= RST_EDGE;
            r.probe_invert_mask           <= RST_INV;
            r.failure_detect_source       <= RST_FSRC;
            r.load_speed_source           <= RST_LSRC;
            r.load_monitor_delay          <= RST_DELAY_MS;
            r.probe_max_measure_time      <= RST_MAXM_MS;
            r.probe_pulses_per_rev        <= RST_PPR;
            r.probe_gear_factor           <= RST_GEAR;
            r.permissible_speed_deviation <= RST_DEV;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata_o          = r.rdata;
    assign load_failure_fault_o = r.load_flt;
    assign deviation_alarm_o    = r.dev_alm;
    assign deviation_fault_o    = r.dev_flt;
    assign probe_speed_result_o = pif.speed;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_load_fault;
        fail_done |=> load_failure_fault_o;
    endproperty
    a_load_fault: assert property (p_load_fault) else $error("load fault not raised");

    property p_cfg_off;
        (r.load_monitor_config == MON_OFF) |-> (!fail_cond && !dev_cond);
    endproperty
    a_cfg_off: assert property (p_cfg_off) else $error("monitoring active while off");

    property p_src_const;
        (r.failure_detect_source == 3'h0) |-> ##1 !fail_done;
    endproperty
    a_src_const: assert property (p_src_const) else $error("failure seen from constant source");

    sequence s_dev_alarm_due;
        dev_done && resp_alarm;
    endsequence
    property p_dev_alarm;
        s_dev_alarm_due |=> deviation_alarm_o && !$rose(deviation_fault_o);
    endproperty
    a_dev_alarm: assert property (p_dev_alarm) else $error("alarm response wrong");

    property p_dev_fault;
        (dev_done && resp_fault) |=> deviation_fault_o ##1 (deviation_fault_o || $past(reg_wr_i));
    endproperty
    a_dev_fault: assert property (p_dev_fault) else $error("fault response wrong");

    property p_no_source;
        !r.load_speed_source |-> (load_speed == 16'h0);
    endproperty
    a_no_source: assert property (p_no_source) else $error("load speed from no source");

    property p_src_probe;
        r.load_speed_source |-> (load_speed == pif.speed);
    endproperty
    a_src_probe: assert property (p_src_probe) else $error("load speed not from probe");

    property p_load_sticky;
        (load_failure_fault_o && !(reg_wr_i && reg_addr_i == A_STATUS && reg_wdata_i[ST_LOAD_FLT])) |=> load_failure_fault_o;
    endproperty
    a_load_sticky: assert property (p_load_sticky) else $error("load fault lost");

    property p_load_cause;
        $rose(load_failure_fault_o) |-> $past(fail_done);
    endproperty
    a_load_cause: assert property (p_load_cause) else $error("load fault without delay");

    property p_fsrc_const;
        (r.failure_detect_source >= 3'h5) |-> fail_in;
    endproperty
    a_fsrc_const: assert property (p_fsrc_const) else $error("failure seen from constant code");

    property p_dev_mode;
        (r.load_monitor_config != MON_SPEED) |-> !dev_cond;
    endproperty
    a_dev_mode: assert property (p_dev_mode) else $error("deviation outside speed mode");

    property p_dev_sticky;
        (deviation_fault_o && !(reg_wr_i && reg_addr_i == A_STATUS && reg_wdata_i[ST_DEV_FLT])) |=> deviation_fault_o;
    endproperty
    a_dev_sticky: assert property (p_dev_sticky) else $error("deviation fault lost");

    property p_dev_cause;
        $rose(deviation_fault_o) |-> $past(dev_done && resp_fault);
    endproperty
    a_dev_cause: assert property (p_dev_cause) else $error("deviation fault without delay");

    property p_alarm_cause;
        deviation_alarm_o |-> $past(dev_done && resp_alarm);
    endproperty
    a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without delay");

    property p_ms_tick;
        r.ms_tick |-> ($past(r.ms_cnt) == 18'(MS_CYCLES - 1));
    endproperty
    a_ms_tick: assert property (p_ms_tick) else $error("millisecond tick spacing wrong");

    property p_alarm_drop;
        !dev_cond |-> ##2 !deviation_alarm_o;
    endproperty
    a_alarm_drop: assert property (p_alarm_drop) else $error("alarm kept after condition ended");
endmodule
`default_nettype wire

/* File: common/lfm_pkg.sv */
`default_nettype none
package lfm_pkg;
    // time base
    localparam int unsigned CLK_HZ      = 250_000_000;
    localparam int unsigned TICK_MS     = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // rpm numerator: 60 s per minute times clock rate
    localparam logic [33:0] SPD_NUM     = 34'(64'(CLK_HZ) * 64'h3c);
    localparam int unsigned DIV_BITS    = 34;
    localparam int unsigned PROBE_MAX_HZ = 32_000;

    // register indices
    localparam logic [2:0] A_CONFIG  = 3'h0;
    localparam logic [2:0] A_DELAY   = 3'h1;
    localparam logic [2:0] A_MAXMEAS = 3'h2;
    localparam logic [2:0] A_PPR     = 3'h3;
    localparam logic [2:0] A_GEAR    = 3'h4;
    localparam logic [2:0] A_DEV     = 3'h5;
    localparam logic [2:0] A_STATUS  = 3'h6;
    localparam logic [2:0] A_SPEED   = 3'h7;

    // config field positions
    localparam int unsigned CFG_MON_LSB  = 0;
    localparam int unsigned CFG_RESP_LSB = 4;
    localparam int unsigned CFG_EDGE_BIT = 8;
    localparam int unsigned CFG_INV_LSB  = 12;
    localparam int unsigned CFG_FSRC_LSB = 16;
    localparam int unsigned CFG_LSRC_BIT = 20;
    localparam int unsigned INV_PROBE_BIT = 3;

    // status bits
    localparam int unsigned ST_LOAD_FLT = 0;
    localparam int unsigned ST_DEV_FLT  = 1;
    localparam int unsigned ST_DEV_ALM  = 2;

    // reset values (10000 ms, 150 rpm)
    localparam logic [1:0]  RST_MON      = 2'h1;
    localparam logic [2:0]  RST_RESP     = 3'h0;
    localparam logic        RST_EDGE     = 1'h0;
    localparam logic [3:0]  RST_INV      = 4'h0;
    localparam logic [2:0]  RST_FSRC     = 3'h0;
    localparam logic        RST_LSRC     = 1'h0;
    localparam logic [31:0] RST_DELAY_MS = 32'h0000_2710;
    localparam logic [31:0] RST_MAXM_MS  = 32'h0000_2710;
    localparam logic [7:0]  RST_PPR      = 8'h01;
    localparam logic [7:0]  RST_GEAR     = 8'h01;
    localparam logic [15:0] RST_DEV      = 16'h0096;

    typedef enum logic [1:0] {
        MON_OFF    = 2'h0,
        MON_TORQUE = 2'h1,
        MON_SPEED  = 2'h2,
        MON_LOAD   = 2'h3
    } lfm_mon_t;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'b01,
        DIV_RUN  = 2'b10
    } lfm_div_st_t;
endpackage
`default_nettype wire

/* File: common/lfm_probe_if.sv */
`default_nettype none
interface lfm_probe_if;
    logic        edge_sel;
    logic        invert;
    logic [7:0]  ppr;
    logic [7:0]  gear;
    logic [31:0] max_ms;
    logic        ms_tick;
    logic [15:0] speed;

    modport host (
        output edge_sel, invert, ppr, gear, max_ms, ms_tick,
        input  speed
    );
    modport probe (
        input  edge_sel, invert, ppr, gear, max_ms, ms_tick,
        output speed
    );
endinterface
`default_nettype wire

/* File: src/lfm_timer.sv */
`default_nettype none
module lfm_timer
    import lfm_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        cond_i,
    input  wire logic        tick_i,
    input  wire logic [31:0] limit_i,
    output logic             done_o
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        done;
    } lfm_tmr_st_t;

    lfm_tmr_st_t r;
    lfm_tmr_st_t next_r;

    always_comb begin
        next_r = r;
        if (!cond_i) begin
            next_r.cnt  = 32'h0;
            next_r.done = 1'b0;
        end else begin
            if (tick_i && r.cnt != 32'hffff_ffff) begin
                next_r.cnt = r.cnt + 32'h1;
            end
            next_r.done = (r.cnt >= limit_i);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign done_o = r.done;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_drop;
        !cond_i;
    endsequence
    property p_restart;
        s_drop |=> (!done_o && r.cnt == 32'h0);
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");
endmodule
`default_nettype wire

/* File: src/lfm_probe.sv */
`default_nettype none
module lfm_probe
    import lfm_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic pulse_input_three_i,
    lfm_probe_if.probe pif
);
    typedef struct packed {
        logic        prev;
        logic        have_prev;
        logic [31:0] period;
        logic [31:0] idle_ms;
        lfm_div_st_t st;
        logic [5:0]  step;
        logic [40:0] rem;
        logic [33:0] quo;
        logic [39:0] dsr;
        logic [15:0] speed;
    } lfm_prb_st_t;

    lfm_prb_st_t r;
    lfm_prb_st_t next_r;
    logic        pin;
    logic        edge_hit;
    logic        timed_out;
    logic [40:0] rem_sh;
    logic [15:0] q16;
    logic [23:0] prod;

    assign pin = pulse_input_three_i ^ pif.invert;
    assign edge_hit  = pif.edge_sel ? (r.prev & ~pin) : (~r.prev & pin);
    assign timed_out = (r.idle_ms >= pif.max_ms);
    assign rem_sh    = {r.rem[39:0], SPD_NUM[r.step]};
    assign q16       = (r.quo[33:16] != 18'h0) ? 16'hffff : r.quo[15:0];
    assign prod      = 24'(q16) * 24'(pif.gear);

    always_comb begin
        next_r      = r;
        next_r.prev = pin;
        if (r.period != 32'hffff_ffff) begin
            next_r.period = r.period + 32'h1;
        end
        if (pif.ms_tick && r.idle_ms != 32'hffff_ffff) begin
            next_r.idle_ms = r.idle_ms + 32'h1;
        end
        unique case (r.st)
            DIV_IDLE: begin
            end
            DIV_RUN: begin
                if (rem_sh >= {1'b0, r.dsr}) begin
                    next_r.rem         = rem_sh - {1'b0, r.dsr};
                    next_r.quo[r.step] = 1'b1;
                end else begin
                    next_r.rem = rem_sh;
                end
                if (r.step == 6'h0) begin
                    next_r.st = DIV_IDLE;
                end else begin
                    next_r.step = r.step - 6'h1;
                end
            end
        endcase
        if (r.st == DIV_RUN && r.step == 6'h0) begin
            next_r.speed = (prod[23:16] != 8'h0) ? 16'hffff : prod[15:0];
        end
        // no pulse in time, speed zero
        if (timed_out) begin
            next_r.speed     = 16'h0;
            next_r.have_prev = 1'b0;
            next_r.st        = DIV_IDLE;
        end
        if (edge_hit) begin
            next_r.period    = 32'h1;
            next_r.idle_ms   = 32'h0;
            next_r.have_prev = 1'b1;
            // rpm = 60*f_clk / (period * pulses per rev)
            if (r.have_prev && !timed_out && r.st == DIV_IDLE) begin
                next_r.st   = DIV_RUN;
                next_r.step = 6'(DIV_BITS - 1);
                next_r.rem  = 41'h0;
                next_r.quo  = 34'h0;
                next_r.dsr  = 40'(r.period) * 40'(pif.ppr);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            r    <= '0;
            r.st <= DIV_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign pif.speed = r.speed;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_timeout;
        timed_out |=> (pif.speed == 16'h0 && r.st == DIV_IDLE);
    endproperty
    a_timeout: assert property (p_timeout) else $error("speed not zeroed on timeout");

    sequence s_calc_start;
        edge_hit && r.have_prev && !timed_out && r.st == DIV_IDLE;
    endsequence
    property p_measure;
        s_calc_start |=> (r.st == DIV_RUN && r.step == 6'(DIV_BITS - 1));
    endproperty
    a_measure: assert property (p_measure) else $error("speed calculation start wrong");

    // one quotient bit per cycle, so the run lasts DIV_BITS cycles
    property p_measure_step;
        (r.st == DIV_RUN && r.step != 6'h0 && !timed_out) |=> (r.st == DIV_RUN && r.step == $past(r.step) - 6'h1);
    endproperty
    a_measure_step: assert property (p_measure_step) else $error("speed calculation step wrong");

    property p_measure_end;
        (r.st == DIV_RUN && r.step == 6'h0) |=> (r.st == DIV_IDLE);
    endproperty
    a_measure_end: assert property (p_measure_end) else $error("speed calculation not ended");
endmodule
`default_nettype wire

/* File: tb/lfm_switch_model.sv */
`default_nettype none
module lfm_switch_model (
    input  wire logic        core_clk_i,
    input  wire logic        en_i,
    input  wire logic [31:0] period_i,
    output logic             pulse_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt;
    always @(posedge core_clk_i) begin
        if (!en_i) begin
            cnt <= 32'h0;
            pulse_o <= 1'b0;
        end else begin
            cnt <= (cnt + 32'h1 >= period_i) ? 32'h0 : cnt + 32'h1;
            pulse_o <= (cnt < (period_i >> 1));
        end
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module testbench
    import lfm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          MS  = 10;
    localparam logic [15:0] SPD = 16'd38396;
    logic        core_clk;
    logic        rst;
    logic        motor_on;
    logic [15:0] motor_spd;
    logic [2:0]  din_lo;
    logic        probe_pulse;
    logic [2:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        load_flt;
    logic        dev_alm;
    logic        dev_flt;
    logic [15:0] spd_o;
    logic        sw_en;
    logic        pedge;
    logic [3:0]  pinv;
    int          n_errors;
    int          check_count;

    lfm_top #(.MS_CYCLES(MS)) lfm_top_i (
        .core_clk_i(core_clk), .rst_i(rst), .motor_on_i(motor_on), .motor_speed_actual_i(motor_spd),
        .din_i({probe_pulse, din_lo}), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .load_failure_fault_o(load_flt),
        .deviation_alarm_o(dev_alm), .deviation_fault_o(dev_flt), .probe_speed_result_o(spd_o)
    );
    lfm_switch_model lfm_switch_model_i (
        .core_clk_i(core_clk), .en_i(sw_en), .period_i(32'd7813), .pulse_o(probe_pulse)
    );

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic cfg(input logic [1:0] mon, input logic [2:0] resp, input logic [2:0] fsrc, input logic lsrc);
        wr(A_CONFIG, 32'(mon) | (32'(resp) << 4) | (32'(pedge) << 8) | (32'(pinv) << 12)
           | (32'(fsrc) << 16) | (32'(lsrc) << 20));
    endtask

    task automatic t_reset();
        rd_chk(A_CONFIG, 32'h0000_0001);
        rd_chk(A_DELAY, 32'h0000_2710);
        rd_chk(A_MAXMEAS, 32'h0000_2710);
        rd_chk(A_PPR, 32'h0000_0001);
        rd_chk(A_GEAR, 32'h0000_0001);
        rd_chk(A_DEV, 32'h0000_0096);
        wr(A_SPEED, 32'h0000_1234);
        rd_chk(A_SPEED, 32'h0);
        wr(A_STATUS, 32'h4);
        rd_chk(A_STATUS, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_load();
        wr(A_DELAY, 32'h4);
        cfg(2'h0, 3'h0, 3'h1, 1'b0);
        motor_on <= 1'b1;
        din_lo <= 3'h0;
        wait_cyc(80);
        `CHK(load_flt, 1'b0)
        cfg(2'h3, 3'h0, 3'h0, 1'b0);
        wait_cyc(80);
        `CHK(load_flt, 1'b0)
        cfg(2'h3, 3'h0, 3'h1, 1'b0);
        wait_cyc(28);
        din_lo <= 3'h1;
        wait_cyc(2);
        din_lo <= 3'h0;
        wait_cyc(25);
        `CHK(load_flt, 1'b0)
        wait_cyc(45);
        `CHK(load_flt, 1'b1)
        wr(A_STATUS, 32'h1);
        rd_chk(A_STATUS, 32'h1);
        din_lo <= 3'h7;
        wr(A_STATUS, 32'h1);
        rd_chk(A_STATUS, 32'h0);
        $display("load failure test done");
    endtask

    task automatic t_probe(input logic e, input logic [3:0] inv);
        pedge = e;
        pinv = inv;
        wr(A_PPR, 32'd100);
        wr(A_GEAR, 32'h2);
        wr(A_MAXMEAS, 32'd1500);
        cfg(2'h3, 3'h0, 3'h0, 1'b0);
        sw_en <= 1'b1;
        wait_cyc(3 * 7813 + 100);
        `CHK(spd_o, SPD)
        rd_chk(A_SPEED, 32'(SPD));
        $display("probe test done");
    endtask

    task automatic t_dev();
        for (int r = 1; r <= 6; r++) begin
            motor_spd <= SPD + 16'd150;
            cfg(2'h2, 3'(r), 3'h0, 1'b1);
            wait_cyc(80);
            `CHK({dev_alm, dev_flt}, 2'b00)
            motor_spd <= (r % 3 == 2) ? SPD - 16'd151 : SPD + 16'd151;
            wait_cyc(25);
            `CHK({dev_alm, dev_flt}, 2'b00)
            wait_cyc(45);
            `CHK({dev_alm, dev_flt}, {r <= 3, r >= 4})
            motor_spd <= SPD;
            wait_cyc(5);
            wr(A_STATUS, 32'h3);
            rd_chk(A_STATUS, 32'h0);
        end
        motor_spd <= 16'd151;
        cfg(2'h2, 3'h1, 3'h0, 1'b0);
        wait_cyc(70);
        `CHK(dev_alm, 1'b1)
        cfg(2'h3, 3'h1, 3'h0, 1'b0);
        wait_cyc(5);
        `CHK(dev_alm, 1'b0)
        $display("deviation test done");
    endtask

    task automatic t_timeout();
        sw_en <= 1'b0;
        wait_cyc(5000);
        `CHK(spd_o != 16'h0, 1'b1)
        wait_cyc(11000);
        `CHK(spd_o, 16'h0)
        $display("timeout test done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        rst = 1'b1;
        motor_on = 1'b0;
        motor_spd = 16'h0;
        din_lo = 3'h7;
        reg_addr = 3'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sw_en = 1'b0;
        pedge = 1'b0;
        pinv = 4'h0;
        n_errors = 0;
        check_count = 0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_load();
        t_probe(1'b0, 4'h7);
        t_probe(1'b1, 4'h8);
        t_dev();
        t_timeout();
        report_and_stop();
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule
`default_nettype wire
